// ==== inc/pht_pkg.sv ====
// Constants shared by the pulse high-width timer: register map, mode fields,
// reset values and the count-source divider.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per 8-bit register.
package pht_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [7:0] PHT_IDX_MODE = 8'h23;  // Timer pair mode.
  localparam logic [7:0] PHT_IDX_PRE = 8'h24;   // Prescaler count.
  localparam logic [7:0] PHT_IDX_TMR = 8'h25;   // Timer count.
  localparam logic [7:0] PHT_IDX_IRQ_REQUEST_ONE = 8'h3c; // Interrupt request one.
  localparam logic [7:0] PHT_IDX_IRQ_REQUEST_TWO = 8'h3d; // Interrupt request two.
  localparam logic [7:0] PHT_IDX_IEN1 = 8'h3e;  // Interrupt enable one.
  localparam logic [7:0] PHT_IDX_IEN2 = 8'h3f;  // Interrupt enable two.

  // Byte addresses derived from the indices.
  localparam logic [7:0] PHT_ADDR_MODE = {PHT_IDX_MODE[5:0], 2'b00};
  localparam logic [7:0] PHT_ADDR_PRE = {PHT_IDX_PRE[5:0], 2'b00};
  localparam logic [7:0] PHT_ADDR_TMR = {PHT_IDX_TMR[5:0], 2'b00};
  localparam logic [7:0] PHT_ADDR_IRQ_REQUEST_ONE = {PHT_IDX_IRQ_REQUEST_ONE[5:0], 2'b00};
  localparam logic [7:0] PHT_ADDR_IRQ_REQUEST_TWO = {PHT_IDX_IRQ_REQUEST_TWO[5:0], 2'b00};
  localparam logic [7:0] PHT_ADDR_IEN1 = {PHT_IDX_IEN1[5:0], 2'b00};
  localparam logic [7:0] PHT_ADDR_IEN2 = {PHT_IDX_IEN2[5:0], 2'b00};

  // Mode register fields.
  localparam int PHT_MODE_OPM_LSB = 0;             // Two-bit operating mode.
  localparam int PHT_MODE_EDGE_BIT = 2;            // 0 measures high, 1 measures low.
  localparam int PHT_MODE_STOP_BIT = 3;            // 1 holds the count stopped.
  localparam logic [1:0] PHT_OPM_PULSE_WIDTH = 2'b11; // Pulse-width measurement.

  // Interrupt request and enable bit positions.
  localparam int PHT_IRQ_TMR_BIT = 0;  // Timer underflow, in request one.
  localparam int PHT_IRQ_PIN_BIT = 0;  // End of active level, in request two.

  // Reset values.
  localparam logic [7:0] PHT_MODE_RST = 8'h08;  // Timer mode, counting stopped.
  localparam logic [7:0] PHT_CNT_RST = 8'hff;   // Prescaler and timer.
  localparam logic [7:0] PHT_IRQ_RST = 8'h00;   // Requests and enables.

  // Count source: main clock divided by sixteen.
  localparam int PHT_DIV_RATIO = 16;
  localparam logic [3:0] PHT_DIV_LAST = 4'(PHT_DIV_RATIO - 1);

  // AXI responses.
  localparam logic [1:0] PHT_RESP_OKAY = 2'b00;
  localparam logic [1:0] PHT_RESP_SLVERR = 2'b10;

endpackage : pht_pkg

// ==== verilog/pht_down_cnt.sv ====
// One 8-bit down counter with a reload latch, used for prescaler and timer.
// Assumes tick and load are one-cycle pulses in the MCLK domain.
`timescale 1ns/1ps
module pht_down_cnt
  import pht_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0] load_val,
  output logic [7:0] count,
  output logic under
);

  // Live count and the value that is reloaded at underflow.
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] reload;
  } pht_cnt_state_t;

  pht_cnt_state_t q; // Registered state.
  pht_cnt_state_t d; // Next state.

  // Underflow is a tick that finds the count at zero.
  assign under = tick && (q.cnt == 8'h00);
  assign count = q.cnt;

  // A write loads both latch and count; otherwise a tick counts down or reloads.
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
      d.reload = load_val;
    end else if (tick) begin
      if (q.cnt == 8'h00) begin
        d.cnt = q.reload;
      end else begin
        d.cnt = q.cnt - 8'h01;
      end
    end
    if (!rst_n) begin
      d.cnt = PHT_CNT_RST;
      d.reload = PHT_CNT_RST;
    end
  end

  // Registers the state.
  always_ff @(posedge clk) begin
    q <= d;
  end

endmodule : pht_down_cnt

// ==== verilog/pht_timer.sv ====
// Pulse high-width timer: divide-by-16 source, cascaded prescaler and timer,
// request and enable registers, all behind an AXI4-Lite slave.
// Assumes COUNTER_INPUT_PIN is already synchronous to MCLK.
//
// Function
// - Pulse-width mode counts only during the input level picked by edge select.
// - Underflow and active-level end raise request bits.
// - Count source is main clock divided by sixteen.
// - Prescaler and timer cascade into sixteen-bit down count.
// - Timer underflow sets its request bit automatically.
// - Stop bit zero counts, one holds stopped.
// - Edge select picks high or low width.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module pht_timer
  import pht_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic COUNTER_INPUT_PIN,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  // Write and read channel states.
  typedef enum logic [1:0] {PHT_W_IDLE = 2'b00, PHT_W_RESP = 2'b01} pht_wst_t;
  typedef enum logic [1:0] {PHT_R_IDLE = 2'b00, PHT_R_RESP = 2'b01} pht_rst_t;

  // All state of the block apart from the two counters and the gap_q check counter.
  typedef struct packed {
    pht_wst_t wst;        // Write channel state.
    logic aw_full;        // Write address captured.
    logic [7:0] aw_addr;  // Captured write address.
    logic w_full;         // Write data captured.
    logic [7:0] w_data;   // Captured low data byte.
    logic w_lane0;        // Captured strobe of byte lane zero.
    logic awready;        // Address channel ready.
    logic wready;         // Data channel ready.
    logic bvalid;         // Write response valid.
    logic [1:0] bresp;    // Write response code.
    pht_rst_t rst;        // Read channel state.
    logic arready;        // Read address ready.
    logic rvalid;         // Read data valid.
    logic [31:0] rdata;   // Read data.
    logic [1:0] rresp;    // Read response code.
    logic [7:0] mode;     // Timer pair mode register.
    logic [7:0] irq_request_one;    // Interrupt request one.
    logic [7:0] irq_request_two;    // Interrupt request two.
    logic [7:0] ien1;     // Interrupt enable one.
    logic [7:0] ien2;     // Interrupt enable two.
    logic [3:0] div;      // Count-source divider.
    logic pin_q;          // Input level of the previous cycle.
  } pht_state_t;

  pht_state_t q; // Registered state.
  pht_state_t d; // Next state.

  logic [7:0] pre_cnt; // Live prescaler count.
  logic [7:0] tmr_cnt; // Live timer count.
  logic pre_under;     // Prescaler underflow pulse.
  logic tmr_under;     // Timer underflow pulse.
  logic pre_load;      // Software write to the prescaler.
  logic tmr_load;      // Software write to the timer.
  logic stop;          // Count stop bit.
  logic pw_mode;       // Pulse-width measurement mode selected.
  logic level_ok;      // Input is at the level being measured.
  logic div_tick;      // One pulse per sixteen running cycles.
  logic cnt_tick;      // Count-source pulse that reaches the prescaler.
  logic pin_end;       // The measured level has just ended.

  // Mode decoding and count gating.
  assign stop = q.mode[PHT_MODE_STOP_BIT];
  assign pw_mode = q.mode[PHT_MODE_OPM_LSB +: 2] == PHT_OPM_PULSE_WIDTH;
  // High width when the edge bit is zero, low width when it is one.
  assign level_ok = COUNTER_INPUT_PIN ^ q.mode[PHT_MODE_EDGE_BIT];
  assign div_tick = !stop && (q.div == PHT_DIV_LAST);
  // Outside pulse-width mode every source pulse counts; inside it only in the level.
  assign cnt_tick = div_tick && (!pw_mode || level_ok);
  // Previous cycle at the measured level, this one not.
  assign pin_end = pw_mode && (q.pin_q ^ q.mode[PHT_MODE_EDGE_BIT]) && !level_ok;

  // Prescaler, clocked by the divided source.
  pht_down_cnt u_pre (
    .clk(MCLK),
    .rst_n(RESET_N),
    .tick(cnt_tick),
    .load(pre_load),
    .load_val(q.w_data),
    .count(pre_cnt),
    .under(pre_under)
  );

  // Timer, clocked by prescaler underflow to form the sixteen-bit span.
  pht_down_cnt u_tmr (
    .clk(MCLK),
    .rst_n(RESET_N),
    .tick(pre_under),
    .load(tmr_load),
    .load_val(q.w_data),
    .count(tmr_cnt),
    .under(tmr_under)
  );

  // Bus slave, register writes, hardware flag setting and synchronous reset.
  always_comb begin
    d = q;
    pre_load = 1'b0;
    tmr_load = 1'b0;
    // Address and data are caught independently, in either order.
    if (AWVALID && q.awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = AWADDR;
      d.awready = 1'b0;
    end
    if (WVALID && q.wready) begin
      d.w_full = 1'b1;
      d.w_data = WDATA[7:0];
      d.w_lane0 = WSTRB[0];
      d.wready = 1'b0;
    end
    case (q.wst)
      PHT_W_IDLE: begin
        // Both halves present: perform the write and answer.
        if (q.aw_full && q.w_full) begin
          d.aw_full = 1'b0;
          d.w_full = 1'b0;
          d.bvalid = 1'b1;
          d.bresp = PHT_RESP_OKAY;
          d.wst = PHT_W_RESP;
          if (q.aw_addr == PHT_ADDR_MODE) begin
            if (q.w_lane0) d.mode = q.w_data;
          end else if (q.aw_addr == PHT_ADDR_PRE) begin
            pre_load = q.w_lane0;
          end else if (q.aw_addr == PHT_ADDR_TMR) begin
            tmr_load = q.w_lane0;
          end else if (q.aw_addr == PHT_ADDR_IRQ_REQUEST_ONE) begin
            // Request bits clear by writing zero; a one leaves them alone.
            if (q.w_lane0) d.irq_request_one = q.irq_request_one & q.w_data;
          end else if (q.aw_addr == PHT_ADDR_IRQ_REQUEST_TWO) begin
            if (q.w_lane0) d.irq_request_two = q.irq_request_two & q.w_data;
          end else if (q.aw_addr == PHT_ADDR_IEN1) begin
            if (q.w_lane0) d.ien1 = q.w_data;
          end else if (q.aw_addr == PHT_ADDR_IEN2) begin
            if (q.w_lane0) d.ien2 = q.w_data;
          end else begin
            d.bresp = PHT_RESP_SLVERR;
          end
        end
      end
      PHT_W_RESP: begin
        // Response taken: reopen both channels.
        if (BREADY) begin
          d.bvalid = 1'b0;
          d.awready = 1'b1;
          d.wready = 1'b1;
          d.wst = PHT_W_IDLE;
        end
      end
      default: begin
        d.wst = PHT_W_IDLE;
      end
    endcase
    case (q.rst)
      PHT_R_IDLE: begin
        // Address taken: look it up and present data next cycle.
        if (ARVALID && q.arready) begin
          d.arready = 1'b0;
          d.rvalid = 1'b1;
          d.rresp = PHT_RESP_OKAY;
          d.rdata = 32'h0000_0000;
          d.rst = PHT_R_RESP;
          if (ARADDR == PHT_ADDR_MODE) begin
            d.rdata[7:0] = q.mode;
          end else if (ARADDR == PHT_ADDR_PRE) begin
            d.rdata[7:0] = pre_cnt;
          end else if (ARADDR == PHT_ADDR_TMR) begin
            d.rdata[7:0] = tmr_cnt;
          end else if (ARADDR == PHT_ADDR_IRQ_REQUEST_ONE) begin
            d.rdata[7:0] = q.irq_request_one;
          end else if (ARADDR == PHT_ADDR_IRQ_REQUEST_TWO) begin
            d.rdata[7:0] = q.irq_request_two;
          end else if (ARADDR == PHT_ADDR_IEN1) begin
            d.rdata[7:0] = q.ien1;
          end else if (ARADDR == PHT_ADDR_IEN2) begin
            d.rdata[7:0] = q.ien2;
          end else begin
            d.rresp = PHT_RESP_SLVERR;
          end
        end
      end
      PHT_R_RESP: begin
        // Data taken: ready for the next address.
        if (RREADY) begin
          d.rvalid = 1'b0;
          d.arready = 1'b1;
          d.rst = PHT_R_IDLE;
        end
      end
      default: begin
        d.rst = PHT_R_IDLE;
      end
    endcase
    // Divider runs only while counting is enabled, so a start is aligned.
    if (stop) begin
      d.div = 4'h0;
    end else begin
      d.div = q.div + 4'h1;
    end
    d.pin_q = COUNTER_INPUT_PIN;
    // Hardware sets come after the software clear, so a set always wins.
    if (tmr_under) d.irq_request_one[PHT_IRQ_TMR_BIT] = 1'b1;
    if (pin_end) d.irq_request_two[PHT_IRQ_PIN_BIT] = 1'b1;
    if (!RESET_N) begin
      d = '0;
      d.awready = 1'b1;
      d.wready = 1'b1;
      d.arready = 1'b1;
      d.mode = PHT_MODE_RST;
      d.irq_request_one = PHT_IRQ_RST;
      d.irq_request_two = PHT_IRQ_RST;
      d.ien1 = PHT_IRQ_RST;
      d.ien2 = PHT_IRQ_RST;
    end
  end

  // Registers the state.
  always_ff @(posedge MCLK) begin
    q <= d;
  end

  // Bus outputs come straight from state flip-flops.
  assign AWREADY = q.awready;
  assign WREADY = q.wready;
  assign BVALID = q.bvalid;
  assign BRESP = q.bresp;
  assign ARREADY = q.arready;
  assign RVALID = q.rvalid;
  assign RDATA = q.rdata;
  assign RRESP = q.rresp;

  // Cycles since the divider last restarted, watched by a check below.
  logic [4:0] gap_q;
  always_ff @(posedge MCLK) begin
    if (!RESET_N || stop || div_tick) begin
      gap_q <= 5'h00;
    end else begin
      gap_q <= gap_q + 5'h01;
    end
  end

  default clocking pht_cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  // A write whose address and data are both held.
  sequence wr_ready_s;
    q.wst == PHT_W_IDLE && q.aw_full && q.w_full;
  endsequence
  // The answer that must follow it.
  sequence wr_answer_s;
    BVALID && !AWREADY && !WREADY;
  endsequence

  high_only_a: assert property (pw_mode && !q.mode[PHT_MODE_EDGE_BIT]
      && !COUNTER_INPUT_PIN |-> !cnt_tick)
    else $error("count source passed while input inactive");
  low_hold_a: assert property (pw_mode && !level_ok && !pre_load && !tmr_load
      |=> $stable(pre_cnt) && $stable(tmr_cnt))
    else $error("count moved while input inactive");
  pin_irq_a: assert property (pin_end |=> q.irq_request_two[PHT_IRQ_PIN_BIT])
    else $error("end of level did not set its request");
  tmr_irq_a: assert property (tmr_under |=> q.irq_request_one[PHT_IRQ_TMR_BIT])
    else $error("timer underflow did not set its request");
  div_sixteen_a: assert property (div_tick |-> gap_q == 5'd15)
    else $error("count source period is not sixteen cycles");
  pre_step_a: assert property (cnt_tick && pre_cnt != 8'h00 && !pre_load
      |=> pre_cnt == $past(pre_cnt) - 8'h01)
    else $error("prescaler did not step down");
  cascade_a: assert property (pre_under && tmr_cnt != 8'h00 && !tmr_load && !pre_load
      |=> tmr_cnt == $past(tmr_cnt) - 8'h01 && pre_cnt == $past(u_pre.q.reload))
    else $error("timer did not step on prescaler underflow");
  stop_hold_a: assert property (stop && !pre_load && !tmr_load
      |=> $stable(pre_cnt) && $stable(tmr_cnt))
    else $error("count moved while stopped");
  low_width_a: assert property (pw_mode && q.mode[PHT_MODE_EDGE_BIT]
      && COUNTER_INPUT_PIN |-> !cnt_tick)
    else $error("low-width mode counted during high input");
  wr_answer_a: assert property (wr_ready_s |=> wr_answer_s)
    else $error("write response did not follow capture");

endmodule : pht_timer

// ==== bench/pht_sensor.sv ====
// Behavioural speed sensor that drives the counter input pin.
// Assumes the pin is sampled on the rising edge of the block's main clock.
`timescale 1ns/1ps
module pht_sensor (
  input wire logic clk,
  output logic pin
);
  // The sensor drives a firm low between pulses; there is no pull on the line.
  initial begin
    pin = 1'b0;
  end

  // Raises the pin for exactly high_cycles clock cycles, then returns it low.
  task automatic pulse(input int high_cycles);
    @(posedge clk);
    pin <= 1'b1;
    repeat (high_cycles) @(posedge clk);
    pin <= 1'b0;
  endtask : pulse
endmodule : pht_sensor

// ==== bench/pulse_high_width_timer_tb_top.sv ====
// Self-checking testbench for the pulse high-width timer.
// Assumes the block's AXI4-Lite timing and its reset values.
`timescale 1ns/1ps
module pulse_high_width_timer_tb_top
  import pht_pkg::*;
;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic COUNTER_INPUT_PIN;
  logic [7:0] AWADDR = 8'h00;
  logic AWVALID = 1'b0;
  logic AWREADY;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic WVALID = 1'b0;
  logic WREADY;
  logic [1:0] BRESP;
  logic BVALID;
  logic BREADY = 1'b1;  // Held high: every response is accepted at once.
  logic [7:0] ARADDR = 8'h00;
  logic ARVALID = 1'b0;
  logic ARREADY;
  logic [31:0] RDATA;
  logic [1:0] RRESP;
  logic RVALID;
  logic RREADY = 1'b1;  // Held high: every read answer is accepted at once.
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] d;
  logic [1:0] r;
  int n;
  logic [7:0] map_a[7] = '{PHT_ADDR_MODE, PHT_ADDR_PRE, PHT_ADDR_TMR, PHT_ADDR_IRQ_REQUEST_ONE,
                           PHT_ADDR_IRQ_REQUEST_TWO, PHT_ADDR_IEN1, PHT_ADDR_IEN2};
  logic [7:0] map_r[7] = '{PHT_MODE_RST, PHT_CNT_RST, PHT_CNT_RST, PHT_IRQ_RST,
                           PHT_IRQ_RST, PHT_IRQ_RST, PHT_IRQ_RST};

  // Main clock, 125 MHz.
  always #4 MCLK = ~MCLK;

  pht_timer pht_timer_i (.MCLK(MCLK), .RESET_N(RESET_N), .COUNTER_INPUT_PIN(COUNTER_INPUT_PIN),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY));

  pht_sensor pht_sensor_i (.clk(MCLK), .pin(COUNTER_INPUT_PIN));

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Compares one value with case equality so an unknown never matches.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One AXI4-Lite write; address and data are offered together and each is
  // released at the edge that takes it. The wait is bounded.
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    int k;
    k = 0;
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= {24'h0, v};
    WSTRB <= s;
    WVALID <= 1'b1;
    do begin
      @(posedge MCLK);
      k++;
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("write response wait", 32'h1, 32'h0);
      summarize();
    end else begin
      chk("write response", {30'h0, er}, {30'h0, BRESP});
    end
  endtask : wr

  // One AXI4-Lite read; data and response are taken at the edge with RVALID high.
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge MCLK);
      k++;
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("read answer wait", 32'h1, 32'h0);
      summarize();
    end else begin
      v = RDATA;
      rs = RRESP;
    end
  endtask : rd

  // Reads a mapped register and compares data and an OKAY response.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk($sformatf("register %h", a), {24'h0, exp}, v);
    chk("read response", {30'h0, PHT_RESP_OKAY}, {30'h0, rs});
  endtask : rchk

  // Main sequence.
  initial begin
    repeat (12) @(posedge MCLK);
    RESET_N <= 1'b1;
    @(posedge MCLK);
    // Reset values, unmapped accesses and a write with no strobe.
    foreach (map_a[i]) rchk(map_a[i], map_r[i]);
    rd(8'h00, d, r);
    chk("unmapped read data", 32'h0, d);
    chk("unmapped read response", {30'h0, PHT_RESP_SLVERR}, {30'h0, r});
    wr(8'h00, 8'h55, 4'h1, PHT_RESP_SLVERR);
    wr(PHT_ADDR_MODE, 8'h00, 4'h0, PHT_RESP_OKAY);
    rchk(PHT_ADDR_MODE, 8'h08);
    $display("Test registers done");
    // Stopped in pulse-width mode: a high input must not move the count.
    wr(PHT_ADDR_PRE, 8'hff, 4'h1, PHT_RESP_OKAY);
    wr(PHT_ADDR_TMR, 8'hff, 4'h1, PHT_RESP_OKAY);
    wr(PHT_ADDR_MODE, 8'h0b, 4'h1, PHT_RESP_OKAY);
    pht_sensor_i.pulse(100);
    rchk(PHT_ADDR_PRE, 8'hff);
    rchk(PHT_ADDR_TMR, 8'hff);
    // The end of the level is flagged even while stopped; clear it for the next test.
    rchk(PHT_ADDR_IRQ_REQUEST_TWO, 8'h01);
    wr(PHT_ADDR_IRQ_REQUEST_TWO, 8'h00, 4'h1, PHT_RESP_OKAY);
    rchk(PHT_ADDR_IRQ_REQUEST_TWO, 8'h00);
    $display("Test stop done");
    // A 320-cycle high level holds exactly twenty divide-by-16 source pulses.
    wr(PHT_ADDR_MODE, 8'h03, 4'h1, PHT_RESP_OKAY);
    pht_sensor_i.pulse(320);
    repeat (4) @(posedge MCLK);
    rchk(PHT_ADDR_PRE, 8'heb);
    rchk(PHT_ADDR_TMR, 8'hff);
    rchk(PHT_ADDR_IRQ_REQUEST_TWO, 8'h01);
    repeat (100) @(posedge MCLK);
    rchk(PHT_ADDR_PRE, 8'heb);
    wr(PHT_ADDR_IRQ_REQUEST_TWO, 8'h00, 4'h1, PHT_RESP_OKAY);
    rchk(PHT_ADDR_IRQ_REQUEST_TWO, 8'h00);
    $display("Test width done");
    // Prescaler 1 and timer 1 cascade to an underflow after four source pulses.
    wr(PHT_ADDR_MODE, 8'h08, 4'h1, PHT_RESP_OKAY);
    wr(PHT_ADDR_PRE, 8'h01, 4'h1, PHT_RESP_OKAY);
    wr(PHT_ADDR_TMR, 8'h01, 4'h1, PHT_RESP_OKAY);
    wr(PHT_ADDR_MODE, 8'h00, 4'h1, PHT_RESP_OKAY);
    repeat (40) @(posedge MCLK);
    rchk(PHT_ADDR_IRQ_REQUEST_ONE, 8'h00);
    n = 0;
    do begin
      rd(PHT_ADDR_IRQ_REQUEST_ONE, d, r);
      n++;
    end while (d[0] !== 1'b1 && n < 40);
    chk("timer request", 32'h1, d);
    wr(PHT_ADDR_MODE, 8'h08, 4'h1, PHT_RESP_OKAY);
    wr(PHT_ADDR_IRQ_REQUEST_ONE, 8'h00, 4'h1, PHT_RESP_OKAY);
    rchk(PHT_ADDR_IRQ_REQUEST_ONE, 8'h00);
    $display("Test underflow done");
    // Low-width mode: three source pulses pass before the input rises, none during it.
    wr(PHT_ADDR_PRE, 8'hff, 4'h1, PHT_RESP_OKAY);
    wr(PHT_ADDR_MODE, 8'h07, 4'h1, PHT_RESP_OKAY);
    repeat (60) @(posedge MCLK);
    pht_sensor_i.pulse(100);
    rchk(PHT_ADDR_PRE, 8'hfc);
    rchk(PHT_ADDR_IRQ_REQUEST_TWO, 8'h01);
    $display("Test low width done");
    // A reset in mid-run brings back the reset values while the count is running.
    RESET_N <= 1'b0;
    repeat (3) @(posedge MCLK);
    RESET_N <= 1'b1;
    @(posedge MCLK);
    rchk(PHT_ADDR_MODE, PHT_MODE_RST);
    rchk(PHT_ADDR_PRE, PHT_CNT_RST);
    rchk(PHT_ADDR_IRQ_REQUEST_TWO, PHT_IRQ_RST);
    $display("Test reset done");
    summarize();
  end
endmodule : pulse_high_width_timer_tb_top
